// ### rtl/nbr_pkg.sv
// package: constants for the nand read host controller
package nbr_pkg;
  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_READ_SETUP = 8'h00;
  localparam logic [7:0] OP_READ_CONFIRM = 8'h30;
  localparam logic [7:0] OP_COPYBACK_CONFIRM = 8'h35;
  localparam logic [7:0] OP_COL_CHANGE = 8'h05;
  localparam logic [7:0] OP_ROW_CHANGE = 8'h06;
  localparam logic [7:0] OP_CHANGE_CONFIRM = 8'he0;
  localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
  localparam logic [7:0] OP_CACHE_END = 8'h3f;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_RESET = 8'hff;
  // ************************************************************
  // host request kinds
  // ************************************************************
  localparam logic [2:0] REQ_PAGE_READ = 3'h0;
  localparam logic [2:0] REQ_COPYBACK = 3'h1;
  localparam logic [2:0] REQ_COL_CHANGE = 3'h2;
  localparam logic [2:0] REQ_ROW_CHANGE = 3'h3;
  localparam logic [2:0] REQ_CACHE_RANDOM = 3'h4;
  localparam logic [2:0] REQ_CACHE_SEQ = 3'h5;
  localparam logic [2:0] REQ_CACHE_END = 3'h6;
  localparam logic [2:0] REQ_STATUS = 3'h7;
  // ************************************************************
  // timing (40 ns clock)
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_LOW_NS = 40; // least low time of a strobe
  localparam int STROBE_HIGH_NS = 40; // least high time of a strobe
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_WAIT_NS = 200; // wait before ready/busy is trusted
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_LOW_CNT = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] STROBE_HIGH_CNT = 4'(STROBE_HIGH_CYC);
  localparam logic [3:0] BUSY_WAIT_CNT = 4'(BUSY_WAIT_CYC);
  // ************************************************************
  // reset values and fifo depth
  // ************************************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int FIFO_DEPTH = 8;
endpackage

// ### rtl/nbr_fifo.sv
// module: parameterised data fifo with valid/ready on both sides
`timescale 1ns/1ps
module nbr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // ************************************************************
  // storage and pointers
  // ************************************************************
  typedef struct packed {
    logic [AW-1:0] wr_ptr; // next slot to fill
    logic [AW-1:0] rd_ptr; // next slot to drain
    logic [AW:0] count; // words held
  } nbr_fifo_state_t;
  nbr_fifo_state_t st_reg;
  nbr_fifo_state_t st_next;
  logic [WIDTH-1:0] mem [DEPTH]; // data array, no reset needed
  logic push;
  logic pull;
  // honest flags straight from the count
  assign o_in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_reg.count != '0);
  assign o_out_data = mem[st_reg.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pull = o_out_valid && i_out_ready;
  // pointer update
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pull)
    begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pull);
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  // data write, kept apart so the array needs no reset
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[st_reg.wr_ptr] <= i_in_data;
    end
  end
endmodule

// ### rtl/nbr_host.sv
// module: nand read-family host controller driving the strobe bus
`timescale 1ns/1ps
module nbr_host #(
  parameter int DATA_W = 16, // 8 or 16 bit bus
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // user request side
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [2:0] i_req_kind,
  input wire logic [15:0] i_req_column,
  input wire logic [23:0] i_req_row,
  input wire logic i_req_long_addr, // row change with five cycles
  input wire logic [15:0] i_req_count, // words to read out
  input wire logic i_wp_enable, // high: allow modify (write protect high)
  // user data side
  output logic o_data_valid,
  input wire logic i_data_ready,
  output logic [DATA_W-1:0] o_data,
  output logic o_ready_busy, // device ready, sampled
  // flash pins
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic o_wp_n,
  input wire logic i_rb_n,
  input wire logic [DATA_W-1:0] i_io,
  output logic [DATA_W-1:0] o_io,
  output logic o_io_oe
);
  // ************************************************************
  // types and state
  // ************************************************************
  typedef enum {
    ST_IDLE, ST_CMD1, ST_ADDR, ST_CMD2, ST_WAIT, ST_BUSY, ST_READ_LO, ST_READ_HI
  } nbr_state_t;
  typedef struct packed {
    nbr_state_t state;
    logic [3:0] timer; // strobe phase counter
    logic phase; // 0 strobe low, 1 strobe high
    logic [2:0] kind; // request in flight
    logic [2:0] addr_idx; // address byte in progress
    logic [2:0] addr_total; // address bytes to send
    logic [39:0] addr_sr; // address bytes, lsb first
    logic [7:0] cmd2; // confirm opcode or none
    logic [15:0] remain; // words left to read
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [DATA_W-1:0] io_out;
    logic io_oe;
    logic rb_seen; // sampled ready/busy
    logic page_loaded; // a page read happened
    logic cache_open; // a cache read command happened
    logic req_rdy; // idle and device ready, kept in a flop
    logic wp_n; // write protect pin level
  } nbr_host_state_t;
  nbr_host_state_t st_reg;
  nbr_host_state_t st_next;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [DATA_W-1:0] fifo_in_data;
  logic timer_done;
  // ************************************************************
  // output fifo, stalls the read strobe when full
  // ************************************************************
  nbr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(o_data_valid),
    .i_out_ready(i_data_ready),
    .o_out_data(o_data)
  );
  assign timer_done = (st_reg.timer == 4'h0);
  // capture on the rising strobe edge: two cycles after fall, data is settled
  assign fifo_in_valid = (st_reg.state == ST_READ_LO) && timer_done;
  // status answers only use the low byte
  assign fifo_in_data = (st_reg.kind == nbr_pkg::REQ_STATUS)
    ? DATA_W'(i_io[7:0]) : i_io;
  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.rb_seen = i_rb_n;
    st_next.wp_n = i_wp_enable;
    st_next.timer = timer_done ? 4'h0 : st_reg.timer - 4'h1;
    case (st_reg.state)
      ST_IDLE:
      begin
        // strobes parked high; select released for standby
        st_next.we_n = 1'b1;
        st_next.re_n = 1'b1;
        st_next.cle = 1'b0;
        st_next.ale = 1'b0;
        st_next.io_oe = 1'b0;
        st_next.ce_n = 1'b1;
        if (i_req_valid && st_reg.rb_seen)
        begin
          st_next.kind = i_req_kind;
          st_next.remain = i_req_count;
          st_next.addr_idx = 3'h0;
          st_next.addr_sr = {i_req_row, 4'h0, i_req_column[11:0]};
          st_next.addr_total = 3'h5;
          st_next.cmd2 = nbr_pkg::OP_READ_CONFIRM;
          st_next.io_out = DATA_W'(nbr_pkg::OP_READ_SETUP);
          case (i_req_kind)
            nbr_pkg::REQ_COPYBACK:
            begin
              st_next.cmd2 = nbr_pkg::OP_COPYBACK_CONFIRM;
            end
            nbr_pkg::REQ_CACHE_RANDOM:
            begin
              st_next.cmd2 = nbr_pkg::OP_CACHE_SEQ;
            end
            nbr_pkg::REQ_COL_CHANGE:
            begin
              st_next.io_out = DATA_W'(nbr_pkg::OP_COL_CHANGE);
              st_next.addr_total = 3'h2;
              st_next.cmd2 = nbr_pkg::OP_CHANGE_CONFIRM;
            end
            nbr_pkg::REQ_ROW_CHANGE:
            begin
              st_next.io_out = DATA_W'(nbr_pkg::OP_ROW_CHANGE);
              st_next.addr_total = i_req_long_addr ? 3'h5 : 3'h2;
              st_next.cmd2 = nbr_pkg::OP_CHANGE_CONFIRM;
            end
            nbr_pkg::REQ_CACHE_SEQ:
            begin
              st_next.io_out = DATA_W'(nbr_pkg::OP_CACHE_SEQ);
              st_next.addr_total = 3'h0;
              st_next.cmd2 = 8'h00;
            end
            nbr_pkg::REQ_CACHE_END:
            begin
              st_next.io_out = DATA_W'(nbr_pkg::OP_CACHE_END);
              st_next.addr_total = 3'h0;
              st_next.cmd2 = 8'h00;
            end
            nbr_pkg::REQ_STATUS:
            begin
              st_next.io_out = DATA_W'(nbr_pkg::OP_STATUS);
              st_next.addr_total = 3'h0;
              st_next.cmd2 = 8'h00;
              st_next.remain = 16'h0001;
            end
            default:
            begin
              st_next.cmd2 = nbr_pkg::OP_READ_CONFIRM;
            end
          endcase
          // out-of-order cache or random requests are dropped
          if (((i_req_kind == nbr_pkg::REQ_CACHE_SEQ
                || i_req_kind == nbr_pkg::REQ_CACHE_RANDOM) && !st_reg.page_loaded)
              || (i_req_kind == nbr_pkg::REQ_CACHE_END && !st_reg.cache_open)
              || ((i_req_kind == nbr_pkg::REQ_COL_CHANGE
                || i_req_kind == nbr_pkg::REQ_ROW_CHANGE) && !st_reg.page_loaded))
          begin
            st_next.state = ST_IDLE;
          end
          else
          begin
            st_next.ce_n = 1'b0;
            st_next.cle = 1'b1;
            st_next.ale = 1'b0;
            st_next.we_n = 1'b0;
            st_next.io_oe = 1'b1;
            st_next.timer = nbr_pkg::STROBE_LOW_CNT;
            st_next.phase = 1'b0;
            st_next.state = ST_CMD1;
          end
        end
      end
      ST_CMD1, ST_ADDR, ST_CMD2:
      begin
        // shared write-strobe phase: low, then rising edge latches
        if (timer_done && !st_reg.phase)
        begin
          st_next.we_n = 1'b1;
          st_next.phase = 1'b1;
          st_next.timer = nbr_pkg::STROBE_HIGH_CNT;
        end
        else if (timer_done)
        begin
          st_next.phase = 1'b0;
          st_next.timer = nbr_pkg::STROBE_LOW_CNT;
          if (st_reg.state != ST_CMD2 && st_reg.addr_idx < st_reg.addr_total)
          begin
            st_next.state = ST_ADDR;
            st_next.cle = 1'b0;
            st_next.ale = 1'b1;
            st_next.we_n = 1'b0;
            st_next.io_out = DATA_W'(st_reg.addr_sr[7:0]);
            st_next.addr_sr = {8'h00, st_reg.addr_sr[39:8]};
            st_next.addr_idx = st_reg.addr_idx + 3'h1;
          end
          else if (st_reg.state != ST_CMD2 && st_reg.cmd2 != 8'h00)
          begin
            st_next.state = ST_CMD2;
            st_next.cle = 1'b1;
            st_next.ale = 1'b0;
            st_next.we_n = 1'b0;
            st_next.io_out = DATA_W'(st_reg.cmd2);
          end
          else
          begin
            st_next.cle = 1'b0;
            st_next.ale = 1'b0;
            st_next.io_oe = 1'b0;
            st_next.timer = nbr_pkg::BUSY_WAIT_CNT;
            st_next.state = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        // let the device pull ready/busy low before polling it
        if (timer_done)
        begin
          st_next.state = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        // both strobes held high until ready
        if (st_reg.rb_seen)
        begin
          if (st_reg.kind == nbr_pkg::REQ_PAGE_READ)
          begin
            st_next.page_loaded = 1'b1;
            st_next.cache_open = 1'b0;
          end
          if (st_reg.kind == nbr_pkg::REQ_CACHE_SEQ || st_reg.kind == nbr_pkg::REQ_CACHE_RANDOM)
          begin
            st_next.cache_open = 1'b1;
          end
          if (st_reg.kind == nbr_pkg::REQ_CACHE_END)
          begin
            st_next.cache_open = 1'b0;
          end
          // copy-back leaves data in the cache, nothing to stream
          if (st_reg.remain == 16'h0000 || st_reg.kind == nbr_pkg::REQ_COPYBACK)
          begin
            st_next.state = ST_IDLE;
          end
          else
          begin
            st_next.state = ST_READ_HI;
            st_next.timer = nbr_pkg::STROBE_HIGH_CNT;
          end
        end
      end
      ST_READ_HI:
      begin
        // only drop the strobe when the fifo has room
        if (timer_done && fifo_in_ready)
        begin
          st_next.re_n = 1'b0;
          st_next.timer = nbr_pkg::STROBE_LOW_CNT;
          st_next.state = ST_READ_LO;
        end
      end
      ST_READ_LO:
      begin
        if (timer_done)
        begin
          st_next.re_n = 1'b1;
          st_next.remain = st_reg.remain - 16'h1;
          st_next.timer = nbr_pkg::STROBE_HIGH_CNT;
          st_next.state = (st_reg.remain == 16'h1) ? ST_IDLE : ST_READ_HI;
        end
      end
      default:
      begin
        st_next.state = ST_IDLE;
      end
    endcase
    // ready flag from the next state so the output needs no gate
    st_next.req_rdy = (st_next.state == ST_IDLE) && st_next.rb_seen;
  end
  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '{state: ST_IDLE, timer: 4'h0, phase: 1'b0, kind: 3'h0, addr_idx: 3'h0,
                  addr_total: 3'h0, addr_sr: 40'h0, cmd2: 8'h00, remain: 16'h0000,
                  ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                  io_out: DATA_W'(nbr_pkg::RST_WORD), io_oe: 1'b0, rb_seen: 1'b0,
                  page_loaded: 1'b0, cache_open: 1'b0, req_rdy: 1'b0, wp_n: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  // ************************************************************
  // pin outputs, all from flops
  // ************************************************************
  assign o_ce_n = st_reg.ce_n;
  assign o_cle = st_reg.cle;
  assign o_ale = st_reg.ale;
  assign o_we_n = st_reg.we_n;
  assign o_read_strobe_n = st_reg.re_n;
  assign o_io = st_reg.io_out;
  assign o_io_oe = st_reg.io_oe;
  assign o_ready_busy = st_reg.rb_seen;
  assign o_req_ready = st_reg.req_rdy;
  // read-family only: write protect follows the user's permission
  assign o_wp_n = st_reg.wp_n;
endmodule

// ### test/nbr_host_sva.sv
// file: concurrent checks on the flash pins of the nand read host
`timescale 1ns/1ps
module nbr_host_sva #(
  parameter int DATA_W = 16 // host data bus width
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic [2:0] i_req_kind,
  input wire logic o_ready_busy,
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_read_strobe_n,
  input wire logic i_rb_n,
  input wire logic [DATA_W-1:0] o_io,
  input wire logic o_io_oe
);
  // ************************************************************
  // one clock domain, so one default clocking and disable
  // ************************************************************
  default clocking dflt @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_latch_excl: assert property (!(o_cle && o_ale))
    else $error("both latch enables high");
  a_cmd_qual: assert property (o_cle && !o_we_n
    |-> !o_ce_n && o_read_strobe_n && o_io_oe ##2 o_we_n) else $error("bad command cycle");
  a_addr_qual: assert property (o_ale && !o_we_n
    |-> !o_ce_n && o_read_strobe_n && o_io_oe ##2 o_we_n) else $error("bad address cycle");
  a_read_qual: assert property (!o_read_strobe_n
    |-> !o_ce_n && !o_cle && !o_ale && o_we_n && !o_io_oe ##2 o_read_strobe_n)
    else $error("bad read cycle");
  a_busy_quiet: assert property (!i_rb_n && !$past(i_rb_n)
    |-> o_we_n && o_read_strobe_n) else $error("strobe while device busy");
  a_fetch_wait: assert property (o_cle && !o_we_n && o_io[7:0] == nbr_pkg::OP_READ_CONFIRM
    |=> o_read_strobe_n [*5]) else $error("read strobe before busy settles");
  a_ready_rise: assert property ($rose(o_req_ready) |-> o_ready_busy && o_we_n)
    else $error("request ready while device busy");
  a_page_open: assert property (i_req_valid && o_req_ready
    && i_req_kind == nbr_pkg::REQ_PAGE_READ |=> o_cle && !o_we_n
    && o_io[7:0] == nbr_pkg::OP_READ_SETUP ##4 o_ale && !o_we_n) else $error("bad page read start");
  a_status_open: assert property (i_req_valid && o_req_ready
    && i_req_kind == nbr_pkg::REQ_STATUS |=> o_cle && !o_we_n
    && o_io[7:0] == nbr_pkg::OP_STATUS) else $error("bad status start");
endmodule
bind nbr_host nbr_host_sva #(.DATA_W(DATA_W)) u_nbr_host_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
  .i_req_kind(i_req_kind), .o_ready_busy(o_ready_busy), .o_ce_n(o_ce_n), .o_cle(o_cle),
  .o_ale(o_ale), .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .i_rb_n(i_rb_n),
  .o_io(o_io), .o_io_oe(o_io_oe)
);

// ### test/nbr_flash_model.sv
// file: behavioural nand device answering the read command family
`timescale 1ns/1ps
module nbr_flash_model #(
  parameter int BUSY_NS = 1200, // array fetch, shortened to keep runs brief
  parameter logic [7:0] STATUS_READY = 8'he0 // status byte when ready
) (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_long_busy, // high: four times slower fetch
  input wire logic [15:0] i_io,
  output logic [15:0] o_io,
  output logic o_rb_n
);
  logic [7:0] last_cmd = 8'hff; // newest accepted opcode
  logic [7:0] addr_q [5]; // address bytes, first at index 0
  int addr_cnt = 0; // address bytes since last opcode
  logic [23:0] cache_row = 24'h0; // page seen by output
  logic [23:0] array_row = 24'h0; // page behind the cache
  logic [11:0] col = 12'h0; // next column to output
  logic busy = 1'b0;
  event fetch_ev;
  assign o_rb_n = ~busy;
  initial
    o_io = 16'h0000;
  // busy ends after the fetch time; no overlap, host waits
  always @(fetch_ev)
  begin
    #(i_long_busy ? 4 * BUSY_NS : BUSY_NS);
    busy = 1'b0;
  end
  // ************************************************************
  // command and address latching on the write strobe rise
  // ************************************************************
  task automatic take_cmd(input logic [7:0] op);
    logic [11:0] a_col;
    logic [23:0] a_row;
    a_col = {addr_q[1][3:0], addr_q[0]};
    a_row = {addr_q[4], addr_q[3], addr_q[2]};
    if (busy && !(op inside {8'h70, 8'h78, 8'hff}))
      return;
    case (op)
      8'h30, 8'h35:
      begin
        cache_row = a_row;
        array_row = a_row;
        col = a_col;
      end
      8'h31:
      begin
        cache_row = array_row;
        array_row = (addr_cnt == 5) ? a_row : array_row + 24'h1;
        col = 12'h000;
      end
      8'h3f:
      begin
        cache_row = array_row;
        col = 12'h000;
      end
      8'he0:
      begin
        col = a_col;
        if (last_cmd == 8'h06 && addr_cnt == 5)
          cache_row = a_row;
      end
      default: ;
    endcase
    if (op inside {8'h30, 8'h35, 8'h31, 8'h3f})
    begin
      busy = 1'b1;
      ->fetch_ev;
    end
    // unknown opcodes leave last_cmd alone; every opcode not dropped while busy clears addr_cnt
    if (op inside {8'h00, 8'h05, 8'h06, 8'h30, 8'h35, 8'h31, 8'h3f, 8'he0, 8'h70, 8'hff})
      last_cmd = op;
    addr_cnt = 0;
  endtask
  always @(posedge i_we_n)
  begin
    if (!i_ce_n && i_read_strobe_n && i_cle && !i_ale)
      take_cmd(i_io[7:0]);
    else if (!i_ce_n && i_read_strobe_n && i_ale && !i_cle && !busy && addr_cnt < 5)
    begin
      addr_q[addr_cnt] = i_io[7:0];
      addr_cnt++;
    end
  end
  // ************************************************************
  // serial output; select is ignored while the strobe is high
  // ************************************************************
  always @(negedge i_read_strobe_n)
  begin
    if (!i_ce_n && !busy)
    begin
      #8;
      if (last_cmd == 8'h70)
        o_io = {8'h00, STATUS_READY};
      else
        o_io = {cache_row[3:0], col};
      col = col + 12'h001;
    end
  end
  // after hold, invert so a stale word can never be mistaken
  always @(posedge i_read_strobe_n)
  begin
    #6;
    o_io = ~o_io;
  end
endmodule

// ### test/nbr_host_bench.sv
// file: self-checking bench for the nand read host
`timescale 1ns/1ps
`define nbr_chk(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
      $display("ERROR time %0t got %0h expected %0h", $time, (got), (exp)); \
    if ((got) !== (exp)) \
      fail_count++; \
  end
module nbr_host_bench;
  localparam logic [7:0] STATUS_READY = 8'he0; // status byte of the model
  localparam int LIMIT = 3000; // cycles before a wait gives up
  logic i_clk, i_rst, i_req_valid, i_req_long_addr, i_wp_enable, i_data_ready, long_busy;
  logic [2:0] i_req_kind;
  logic [15:0] i_req_column, i_req_count, o_data, o_io, i_io, mdl_io;
  logic [23:0] i_req_row;
  logic o_req_ready, o_data_valid, o_ready_busy, o_ce_n, o_cle, o_ale, o_we_n;
  logic o_read_strobe_n, o_wp_n, i_rb_n, o_io_oe;
  int fail_count = 0;
  int tests_run = 0;
  int we_falls = 0; // write strobe pulses seen
  int re_falls = 0; // read strobe pulses seen
  int busy_seen = 0; // busy periods seen
  assign i_io = o_io_oe ? o_io : mdl_io; // host wins while enabled
  always @(negedge o_we_n) we_falls++;
  always @(negedge o_read_strobe_n) re_falls++;
  always @(negedge i_rb_n) busy_seen++;
  nbr_host #(.DATA_W(16), .FIFO_DEPTH(8)) u_nbr_host (
    .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .i_req_kind(i_req_kind), .i_req_column(i_req_column), .i_req_row(i_req_row),
    .i_req_long_addr(i_req_long_addr), .i_req_count(i_req_count), .i_wp_enable(i_wp_enable),
    .o_data_valid(o_data_valid), .i_data_ready(i_data_ready), .o_data(o_data),
    .o_ready_busy(o_ready_busy), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
    .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .i_rb_n(i_rb_n),
    .i_io(i_io), .o_io(o_io), .o_io_oe(o_io_oe));
  nbr_flash_model #(.STATUS_READY(STATUS_READY)) u_nbr_flash_model (
    .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_read_strobe_n(o_read_strobe_n), .i_long_busy(long_busy), .i_io(i_io),
    .o_io(mdl_io), .o_rb_n(i_rb_n));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  function automatic logic [15:0] word(input logic [23:0] row, input logic [11:0] col);
    return {row[3:0], col}; // page pattern of the model
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    `nbr_chk(1'b0, 1'b1) // wait limit used up
    wrap_up();
  endtask
  // one request, held until the controller takes it
  task automatic request(input logic [2:0] kind, input logic [15:0] col,
                         input logic [23:0] row, input logic long_addr, input logic [15:0] cnt);
    int n;
    @(negedge i_clk);
    i_req_kind = kind;
    i_req_column = col;
    i_req_row = row;
    i_req_long_addr = long_addr;
    i_req_count = cnt;
    i_req_valid = 1'b1;
    for (n = 0; n < LIMIT && o_req_ready !== 1'b1; n++)
      @(negedge i_clk);
    if (n == LIMIT)
      give_up();
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask
  // n words from the buffer, rising by step from first
  task automatic expect_words(input logic [15:0] first, input logic step, input int n);
    int k;
    int w;
    for (k = 0; k < n; k++)
    begin
      for (w = 0; w < LIMIT && o_data_valid !== 1'b1; w++)
        @(negedge i_clk);
      if (w == LIMIT)
        give_up();
      `nbr_chk(o_data, first + (step ? 16'(k) : 16'h0000))
      @(negedge i_clk);
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_refused();
    int w0;
    w0 = we_falls;
    request(nbr_pkg::REQ_CACHE_END, 16'h0000, 24'h0, 1'b0, 16'h0001);
    request(nbr_pkg::REQ_COL_CHANGE, 16'h0010, 24'h0, 1'b0, 16'h0001);
    repeat (20) @(negedge i_clk);
    `nbr_chk(we_falls - w0, 0)
    `nbr_chk(o_data_valid, 1'b0)
  endtask
  task automatic t_page_random();
    int b0;
    b0 = busy_seen;
    request(nbr_pkg::REQ_PAGE_READ, 16'h07fc, 24'h000123, 1'b0, 16'h0004);
    expect_words(word(24'h123, 12'h7fc), 1'b1, 4);
    `nbr_chk(busy_seen - b0, 1)
    request(nbr_pkg::REQ_COL_CHANGE, 16'h0010, 24'h0, 1'b0, 16'h0003);
    expect_words(word(24'h123, 12'h010), 1'b1, 3);
    request(nbr_pkg::REQ_ROW_CHANGE, 16'h0020, 24'h000456, 1'b1, 16'h0002);
    expect_words(word(24'h456, 12'h020), 1'b1, 2);
    request(nbr_pkg::REQ_ROW_CHANGE, 16'h0030, 24'h000789, 1'b0, 16'h0002);
    expect_words(word(24'h456, 12'h030), 1'b1, 2);
  endtask
  task automatic t_cache();
    int b0;
    b0 = busy_seen;
    request(nbr_pkg::REQ_PAGE_READ, 16'h0000, 24'h000200, 1'b0, 16'h0001);
    expect_words(word(24'h200, 12'h000), 1'b1, 1);
    request(nbr_pkg::REQ_CACHE_SEQ, 16'h0000, 24'h0, 1'b0, 16'h0002);
    expect_words(word(24'h200, 12'h000), 1'b1, 2);
    request(nbr_pkg::REQ_CACHE_SEQ, 16'h0000, 24'h0, 1'b0, 16'h0002);
    expect_words(word(24'h201, 12'h000), 1'b1, 2);
    request(nbr_pkg::REQ_CACHE_RANDOM, 16'h0040, 24'h000300, 1'b0, 16'h0002);
    expect_words(word(24'h202, 12'h000), 1'b1, 2);
    request(nbr_pkg::REQ_CACHE_END, 16'h0000, 24'h0, 1'b0, 16'h0002);
    expect_words(word(24'h300, 12'h000), 1'b1, 2);
    `nbr_chk(busy_seen - b0, 5)
  endtask
  task automatic t_copyback_status();
    int b0;
    b0 = busy_seen;
    request(nbr_pkg::REQ_COPYBACK, 16'h0000, 24'h000500, 1'b0, 16'h0000);
    repeat (60) @(negedge i_clk);
    `nbr_chk(o_data_valid, 1'b0)
    `nbr_chk(busy_seen - b0, 1)
    request(nbr_pkg::REQ_STATUS, 16'h0000, 24'h0, 1'b0, 16'h0001);
    expect_words({8'h00, STATUS_READY}, 1'b0, 1);
  endtask
  // buffer fills while the user stalls and the device is slow
  task automatic t_fifo();
    int r0;
    logic ok;
    i_data_ready = 1'b0;
    long_busy = 1'b1;
    r0 = re_falls;
    request(nbr_pkg::REQ_PAGE_READ, 16'h0000, 24'h000600, 1'b0, 16'h000c);
    repeat (250) @(negedge i_clk);
    ok = (re_falls - r0) inside {8, 9};
    `nbr_chk(ok, 1'b1)
    i_data_ready = 1'b1;
    expect_words(word(24'h600, 12'h000), 1'b1, 12);
    repeat (4) @(negedge i_clk);
    `nbr_chk(o_data_valid, 1'b0)
    long_busy = 1'b0;
  endtask
  task automatic t_wp();
    i_wp_enable = 1'b1;
    repeat (2) @(negedge i_clk);
    `nbr_chk(o_wp_n, 1'b1)
    i_wp_enable = 1'b0;
    repeat (2) @(negedge i_clk);
    `nbr_chk(o_wp_n, 1'b0)
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    i_rst = 1'b1;
    {i_req_valid, i_req_long_addr, i_wp_enable, long_busy} = 4'h0;
    i_data_ready = 1'b1;
    i_req_kind = 3'h0;
    i_req_column = 16'h0000;
    i_req_row = 24'h000000;
    i_req_count = 16'h0000;
    repeat (6) @(negedge i_clk);
    `nbr_chk({o_ce_n, o_we_n, o_read_strobe_n, o_io_oe, o_cle, o_ale}, 6'h38)
    i_rst = 1'b0;
    t_refused();
    t_page_random();
    t_cache();
    t_copyback_status();
    t_fifo();
    t_wp();
    wrap_up();
  end
endmodule
